// *** verilog/sps_pkg.sv ***
// Package of constants and carriers for the sensor power and reset sequencing block
`default_nettype none
package sps_pkg;
    localparam int          CLK_HZ           = 10_000_000;
    localparam int          INIT_EXTCLKS     = 150000;
    localparam logic [17:0] INIT_CNT_RST     = 18'h00000;
    localparam logic [2:0]  CTRL_STREAM_BIT  = 3'h2;
    localparam logic [15:0] CTRL_REG_ADDR    = 16'h301a;
    localparam logic [15:0] CTRL_RESET_VALUE = 16'h0000;
    localparam int          PIX_WIDTH        = 12;

    typedef enum logic [2:0] {
        SPS_ST_RESET   = 3'b000,
        SPS_ST_INIT    = 3'b001,
        SPS_ST_STANDBY = 3'b010,
        SPS_ST_STREAM  = 3'b011,
        SPS_ST_DRAIN   = 3'b100
    } sps_state_e;

    // Control write from the serial configuration path
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [15:0] data;
    } sps_wr_s;

    // Timing markers from the readout engine
    typedef struct packed {
        logic row_end;
        logic frame_end;
    } sps_rdo_s;
endpackage : sps_pkg
`default_nettype wire

// *** verilog/sps_init_timer.sv ***
// Counter that times the internal initialization in input-clock cycles
`default_nettype none
module sps_init_timer #(
    parameter int INIT_EXTCLKS = sps_pkg::INIT_EXTCLKS
) (
    input  wire logic clk,       // Input clock domain
    input  wire logic rst,       // Synchronous reset, active high
    input  wire logic ce,        // Clock enable
    input  wire logic start,     // Restart count, held during hard reset
    output logic      done       // Initialization complete, level
);
    logic [17:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (rst || (ce && start)) begin
            cnt_reg <= sps_pkg::INIT_CNT_RST;
            done    <= 1'b0;
        end else if (ce && !done) begin
            if (cnt_reg == 18'(INIT_EXTCLKS - 1)) begin
                done <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 18'h00001;
            end
        end
    end
endmodule : sps_init_timer
`default_nettype wire

// *** verilog/sps_sequencer.sv ***
// Reset, initialization, standby and streaming control of the image sensor
// Overview of operation
// - While hard reset is asserted the parallel pixel pins are high impedance.
// - After reset the device initializes for 150000 input clocks into standby.
// - Writing one to bit 2 of control register 0x301a starts streaming.
// - After the streaming bit clears, standby follows the end of the row or frame.
`default_nettype none
module sps_sequencer #(
    parameter int INIT_EXTCLKS = sps_pkg::INIT_EXTCLKS,
    parameter int PIX_WIDTH    = sps_pkg::PIX_WIDTH
) (
    input  wire logic                 clk,           // Input clock
    input  wire logic                 rst,           // Synchronous reset, active high
    input  wire logic                 ce,            // Clock enable
    input  wire logic                 hard_reset_n,  // Hard reset pin, active low
    input  wire sps_pkg::sps_wr_s     cfg_wr,        // Control register write
    input  wire logic                 stop_on_frame, // 1 stop at frame end, 0 at row end
    input  wire sps_pkg::sps_rdo_s    rdo,           // Row and frame end markers
    input  wire logic [PIX_WIDTH-1:0] pix_data,      // Pixel data from readout
    input  wire logic                 pix_valid,     // Pixel data valid
    output logic [PIX_WIDTH-1:0]      pix_out,       // Parallel pixel output
    output logic [PIX_WIDTH-1:0]      pix_oe,        // Pixel output enables
    output logic                      init_done,     // Initialization finished
    output logic                      streaming,     // Streaming active
    output logic                      soft_standby,  // In software standby
    output logic [15:0]               ctrl_value     // Control register contents
);
    sps_pkg::sps_state_e state_reg;
    sps_pkg::sps_state_e state_next;
    logic [15:0]         ctrl_reg;
    logic                init_ok;
    logic                stream_bit;
    logic                stop_point;

    sps_init_timer #(
        .INIT_EXTCLKS(INIT_EXTCLKS)
    ) u_init (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .start(!hard_reset_n),
        .done (init_ok)
    );

    // Control register; the hard reset pin returns it to its reset value
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= sps_pkg::CTRL_RESET_VALUE;
        end else if (ce) begin
            if (!hard_reset_n) begin
                ctrl_reg <= sps_pkg::CTRL_RESET_VALUE;
            end else if (cfg_wr.valid && init_ok
                         && cfg_wr.addr == sps_pkg::CTRL_REG_ADDR) begin
                ctrl_reg <= cfg_wr.data;
            end
        end
    end

    assign stream_bit = ctrl_reg[sps_pkg::CTRL_STREAM_BIT];
    assign stop_point = stop_on_frame ? rdo.frame_end : rdo.row_end;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sps_pkg::SPS_ST_RESET: begin
                state_next = sps_pkg::SPS_ST_INIT;
            end
            sps_pkg::SPS_ST_INIT: begin
                if (init_ok) begin
                    state_next = sps_pkg::SPS_ST_STANDBY;
                end
            end
            sps_pkg::SPS_ST_STANDBY: begin
                if (stream_bit) begin
                    state_next = sps_pkg::SPS_ST_STREAM;
                end
            end
            sps_pkg::SPS_ST_STREAM: begin
                if (!stream_bit) begin
                    state_next = stop_point ? sps_pkg::SPS_ST_STANDBY
                                            : sps_pkg::SPS_ST_DRAIN;
                end
            end
            sps_pkg::SPS_ST_DRAIN: begin
                if (stop_point) begin
                    state_next = sps_pkg::SPS_ST_STANDBY;
                end
            end
            default: begin
                state_next = sps_pkg::SPS_ST_RESET;
            end
        endcase
        if (!hard_reset_n) begin
            state_next = sps_pkg::SPS_ST_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= sps_pkg::SPS_ST_RESET;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Pixel pins float under hard reset and outside streaming
    always_ff @(posedge clk) begin
        if (rst) begin
            pix_out <= '0;
            pix_oe  <= '0;
        end else if (ce) begin
            if (!hard_reset_n) begin
                pix_oe  <= '0;
                pix_out <= '0;
            end else if (state_next == sps_pkg::SPS_ST_STREAM
                         || state_next == sps_pkg::SPS_ST_DRAIN) begin
                pix_oe <= '1;
                if (pix_valid) begin
                    pix_out <= pix_data;
                end
            end else begin
                pix_oe  <= '0;
                pix_out <= '0;
            end
        end
    end

    assign init_done    = init_ok;
    assign streaming    = (state_reg == sps_pkg::SPS_ST_STREAM)
                       || (state_reg == sps_pkg::SPS_ST_DRAIN);
    assign soft_standby = (state_reg == sps_pkg::SPS_ST_STANDBY);
    assign ctrl_value   = ctrl_reg;
endmodule : sps_sequencer
`default_nettype wire

// *** testbench/sps_seq_props.sv ***
// Port assertions for the sequencer
`default_nettype none
module sps_seq_props #(parameter int INIT_EXTCLKS = 20, parameter int PIX_WIDTH = 12) (
    input wire logic                 clk,           // Clock
    input wire logic                 rst,           // Reset
    input wire logic                 ce,            // Enable
    input wire logic                 hard_reset_n,  // Hard reset
    input wire sps_pkg::sps_wr_s     cfg_wr,        // Write
    input wire logic                 stop_on_frame, // Stop mode
    input wire sps_pkg::sps_rdo_s    rdo,           // Markers
    input wire logic [PIX_WIDTH-1:0] pix_oe,        // Enables
    input wire logic                 init_done,     // Init done
    input wire logic                 streaming,     // Streaming
    input wire logic                 soft_standby,  // Standby
    input wire logic [15:0]          ctrl_value     // Control
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    int   cnt_reg;
    logic wr_ok;
    logic st_go;
    logic stop_ok;
    assign wr_ok = ce && cfg_wr.valid && cfg_wr.addr == sps_pkg::CTRL_REG_ADDR
        && init_done && hard_reset_n;
    assign st_go = wr_ok && cfg_wr.data[2] && soft_standby;
    assign stop_ok = streaming && !ctrl_value[2] && ce && hard_reset_n;
    // Edges with hard reset released, saturating at the init length
    always_ff @(posedge clk) begin
        if (rst || (ce && !hard_reset_n)) cnt_reg <= 0;
        else if (ce && cnt_reg < INIT_EXTCLKS) cnt_reg <= cnt_reg + 1;
    end
    a_oe_off_reset: assert property (ce && !hard_reset_n |=> pix_oe == '0)
        else $error("pins driven in reset");
    a_init_count: assert property (init_done == (cnt_reg >= INIT_EXTCLKS))
        else $error("init length wrong");
    a_write_taken: assert property (wr_ok |=> ctrl_value == $past(cfg_wr.data))
        else $error("write lost");
    a_write_refused: assert property (hard_reset_n && !wr_ok |=> $stable(ctrl_value))
        else $error("write not refused");
    a_stream_start: assert property (st_go ##1 ce && hard_reset_n |=> streaming)
        else $error("stream late");
    a_oe_streaming: assert property (streaming |-> pix_oe == '1)
        else $error("pins idle in stream");
    a_drain_hold: assert property (stop_ok && !rdo.row_end && !rdo.frame_end |=> streaming)
        else $error("stopped early");
    a_stop_mark: assert property (stop_ok && (stop_on_frame ? rdo.frame_end : rdo.row_end)
        |=> soft_standby && pix_oe == '0)
        else $error("no standby at marker");
    cover property (st_go);
    cover property ($rose(init_done));
    cover property ($fell(streaming) && soft_standby);
endmodule // sps_seq_props
bind sps_sequencer sps_seq_props #(.INIT_EXTCLKS(INIT_EXTCLKS), .PIX_WIDTH(PIX_WIDTH)) u_props (.*);
`default_nettype wire

// *** testbench/sps_host_model.sv ***
// Host model that drives the active-low hard reset
`default_nettype none
module sps_host_model #(parameter int HOLD = 12) (
    input  wire logic clk,          // Clock
    input  wire logic go,           // Start reset
    output var logic  hard_reset_n  // Hard reset
);
    timeunit 1ns;
    timeprecision 1ns;
    int         cnt = 0;
    logic [4:0] rails = 5'h00; // PLL, analog and pixel, I/O, core, serial-output
    initial hard_reset_n = 1'b0;
    always @(posedge clk) begin
        // All rails drop at once on a restart: zero spacing is allowed
        rails <= go ? 5'h00 : {rails[3:0], 1'b1};
        cnt <= go ? HOLD : (cnt > 0 ? cnt - 1 : 0);
        // Reset lets go only once every rail and the input clock are up
        hard_reset_n <= !go && cnt == 0 && rails == 5'h1f;
    end
endmodule // sps_host_model
`default_nettype wire

// *** testbench/test_sensor_power_sequencing.sv ***
// Self-checking bench for the sequencer
`default_nettype none
module test_sensor_power_sequencing;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INIT = 20;
    logic clk = 0, rst = 1, ce = 1, go = 1, hrn, sof = 0, pv = 0, id, st, sb;
    sps_pkg::sps_wr_s  wr = '0;
    sps_pkg::sps_rdo_s rdo = '0;
    logic [11:0] pd = 12'h5a3, po, oe;
    logic [15:0] cv;
    int error_cnt = 0, cmp_count = 0;
    sps_host_model #(.HOLD(12)) host (.clk(clk), .go(go), .hard_reset_n(hrn));
    sps_sequencer #(.INIT_EXTCLKS(INIT)) DUT (.clk(clk), .rst(rst), .ce(ce),
        .hard_reset_n(hrn), .cfg_wr(wr), .stop_on_frame(sof), .rdo(rdo), .pix_data(pd),
        .pix_valid(pv), .pix_out(po), .pix_oe(oe), .init_done(id), .streaming(st),
        .soft_standby(sb), .ctrl_value(cv));
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr16(input logic [15:0] d, input logic [15:0] a = 16'h301a);
        @(posedge clk) wr <= '{1'b1, a, d};
        @(posedge clk) wr <= '0;
        #1;
    endtask
    task automatic mark(input logic row, input logic frame);
        @(posedge clk) rdo <= '{row, frame};
        @(posedge clk) rdo <= '0;
        #1;
    endtask
    task automatic t_init;
        int n = 0;
        wr16(16'h0004);
        chk(cv, 16'h0000);
        chk(oe, 12'h000);
        while (id !== 1'b1 && n < 200) begin
            if (hrn === 1'b1) n++;
            @(posedge clk);
            #1;
        end
        chk(n, INIT);
        @(posedge clk) #1 chk(sb, 1'b1);
        wr16(16'h0004, 16'h301b);
        chk(cv, 16'h0000);
    endtask
    task automatic t_stream(input logic f);
        @(posedge clk) sof <= f;
        pv <= 1'b1;
        repeat (10) @(posedge clk);
        wr16(16'h0004);
        chk(cv, 16'h0004);
        @(posedge clk) #1 chk(st, 1'b1);
        chk(oe, 12'hfff);
        chk(po, pd);
        wr16(16'h0000);
        if (f) mark(1'b1, 1'b0);
        chk(st, 1'b1);
        mark(!f, f);
        chk(sb, 1'b1);
        chk(oe, 12'h000);
    endtask
    task automatic t_hard;
        wr16(16'h0004);
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        @(posedge clk) #1 chk(oe, 12'h000);
        chk(cv, 16'h0000);
        chk(st, 1'b0);
        chk(id, 1'b0);
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        go <= 1'b0;
        t_init();
        t_stream(1'b0);
        t_stream(1'b1);
        t_hard();
        print_verdict();
    end
    initial begin
        #100us;
        error_cnt++;
        print_verdict();
    end
endmodule // test_sensor_power_sequencing
`default_nettype wire
